//--- testbench/ucc_base_tb_top.sv
// Self-checking bench for the UART control channel
`timescale 1ns/1ns
module ucc_base_tb_top;
    import ucc_pkg::*;
    localparam logic [15:0] BC      = 16'h0008;
    localparam int          TMO [3] = '{50, 100, 200};
    localparam int          DL [4]  = '{0, 4, 8, 1};
    logic        clock = 1'b0, reset = 1'b1, uart_rx_pin, uart_tx_pin, mode_select_pin = 1'b0;
    logic [1:0]  uart_first_byte_delay = 2'h0, bypass_idle_timeout = 2'h3, link_rx_valid = 2'h0;
    logic        local_channel_pin_disable = 1'b0, remote_channel_disable = 1'b0;
    logic        mode_pin_control_enable = 1'b0, bypass_enable_set = 1'b0, link_select = 1'b0;
    logic [1:0]  link_tx_valid, link_tx_bypass_level, link_rx_ready;
    logic [1:0]  link_rx_bypass_level = 2'h3;
    logic [7:0]  link_tx_data, rx_byte;
    logic [15:0] link_rx_data = 16'h0000;
    logic        bypass_active, bypass_enable, rx_frame_error, rx_done;
    logic [9:0]  q_link [$];
    logic [7:0]  q_uart [$];
    int          n_errors = 0, checked = 0, cyc = 0, n, fe = 0;

    always #5 clock = ~clock;

    ucc_base #(.TIMEOUT_2MS_CYCLES(TIMEOUT_WIDTH'(TMO[0])),
        .TIMEOUT_8MS_CYCLES(TIMEOUT_WIDTH'(TMO[1])),
        .TIMEOUT_32MS_CYCLES(TIMEOUT_WIDTH'(TMO[2]))) DUT (
        .bit_cycles(BC), .*);

    ucc_host host (.clock(clock), .bit_cycles(BC), .rx_line(uart_tx_pin),
        .tx_line(uart_rx_pin), .rx_byte(rx_byte), .rx_done(rx_done));

    ////////////////////////////////////////////////////////////////////////////////
    task tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task final_report();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // Host frame; noted only when forwarding is expected
    task hsend(input logic [7:0] v, input bit fwd);
        if (fwd) q_link.push_back({2'h1 << link_select, v});
        host.put(v);
    endtask : hsend
    // Offered on both links; only the selected one may take it
    task lsend(input logic [7:0] v);
        q_uart.push_back(v);
        link_rx_data = {v, v};
        link_rx_valid = 2'h3;
        n = 0;
        @(posedge clock);
        while (link_rx_ready[link_select] !== 1'b1 && n < 500) begin
            @(posedge clock);
            n++;
        end
        #1;
        link_rx_valid = 2'h0;
    endtask : lsend
    ////////////////////////////////////////////////////////////////////////////////
    // Results against the oldest note
    always @(posedge clock) begin
        if (link_tx_valid !== 2'h0) chk("link byte", q_link.size() ? q_link.pop_front() : 10'h3ff,
            {link_tx_valid, link_tx_data});
        if (rx_done) chk("uart byte", q_uart.size() ? q_uart.pop_front() : 9'h1ff, rx_byte);
        if (rx_frame_error === 1'b1) fe++;
    end
    // Hang guard, well above the expected run length
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        void'($urandom(32'hb797));
        tick(12);
        reset = 1'b0;
        tick(5);
        chk("mode", 0, bypass_active);
        for (int l = 0; l < 2; l++) begin
            link_select = l[0];
            for (int k = 0; k < 1 + 2 * l; k++) hsend(8'($urandom), 1);
            host.quiet();
        end
        chk("host left", 0, 16'(q_link.size()));
        $display("host frames test done");
        for (int c = 0; c < 4; c++) begin
            uart_first_byte_delay = c[1:0];
            tick(80 * BC);
            lsend(8'($urandom));
            for (n = 0; n < 400 && uart_tx_pin !== 1'b0; n++) tick(1);
            chk("first delay", 16'(2 + DL[c] * BC), 16'(n));
            lsend(8'($urandom));
        end
        tick(30 * BC);
        chk("uart left", 0, 16'(q_uart.size()));
        $display("first byte delay test done");
        remote_channel_disable = 1'b1;
        hsend(8'h5a, 0);
        host.quiet();
        remote_channel_disable = 1'b0;
        local_channel_pin_disable = 1'b1;
        hsend(8'ha5, 0);
        host.quiet();
        local_channel_pin_disable = 1'b0;
        host.tx_line = 1'b0; // Stop bit read low
        tick(10 * BC);
        host.tx_line = 1'b1;
        host.quiet();
        chk("frame error", 1, 16'(fe));
        $display("disable test done");
        bypass_enable_set = 1'b1;
        tick(1);
        bypass_enable_set = 1'b0;
        tick(2);
        chk("bypass", 1, bypass_active);
        fork
            host.put(8'h00);
        join_none
        tick(4 * BC);
        chk("raw level", 16'h1, link_tx_bypass_level);
        tick(300);
        chk("hold", 1, bypass_enable);
        for (int c = 0; c < 3; c++) begin
            bypass_enable_set = 1'b1;
            tick(1);
            bypass_enable_set = 1'b0;
            fork
                host.put(8'h00);
            join_none
            tick(10 * BC);
            // Field set once the low run has restarted the idle count
            bypass_idle_timeout = c[1:0];
            for (n = 0; n < 1000 && bypass_enable === 1'b1; n++) tick(1);
            chk("bypass exit", 1, 16'(n + BC + 8 > TMO[c] && n <= TMO[c] + 8));
        end
        tick(4);
        hsend(8'h3c, 1);
        host.quiet();
        $display("bypass test done");
        mode_pin_control_enable = 1'b1;
        mode_select_pin = 1'b1;
        tick(8);
        chk("pin high", 1, bypass_active);
        mode_select_pin = 1'b0;
        tick(8);
        chk("pin low", 0, bypass_active);
        $display("mode pin test done");
        final_report();
    end
endmodule : ucc_base_tb_top

//--- testbench/ucc_chk.sv
// Port checker for the UART control channel
`timescale 1ns/1ns
module ucc_chk
    import ucc_pkg::*;
(
    input wire logic                          clock,
    input wire logic                          reset,
    input wire logic                          uart_tx_pin,
    input wire logic                          mode_select_pin,
    input wire logic                          local_channel_pin_disable,
    input wire logic                          remote_channel_disable,
    input wire logic                          mode_pin_control_enable,
    input wire logic                          link_select,
    input wire logic [ucc_pkg::NUM_LINKS-1:0] link_tx_valid,
    input wire logic [ucc_pkg::NUM_LINKS-1:0] link_tx_bypass_level,
    input wire logic [ucc_pkg::NUM_LINKS-1:0] link_rx_ready,
    input wire logic                          bypass_active,
    input wire logic                          bypass_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    // Mode, steering and disable relations
    boot_base_a: assert property ($fell(reset) |-> !bypass_active && uart_tx_pin)
        else $error("not in base mode after reset");
    one_link_a: assert property (|link_tx_valid |-> link_tx_valid == (2'h1 << link_select))
        else $error("byte sent to unselected link");
    unsel_ready_a: assert property ($stable(link_select) |-> !link_rx_ready[~link_select])
        else $error("unselected link ready");
    unsel_level_a: assert property ($stable(link_select) |-> link_tx_bypass_level[~link_select])
        else $error("unselected link level not high");
    byp_ready_a: assert property (bypass_active && $past(bypass_active) |-> link_rx_ready == '0)
        else $error("link ready in bypass");
    byp_quiet_a: assert property (bypass_active |-> link_tx_valid == '0)
        else $error("frame decoded in bypass");
    pin_off_a: assert property (local_channel_pin_disable [*2] |-> uart_tx_pin)
        else $error("tx pin driven while disabled");
    rem_off_a: assert property (remote_channel_disable [*2] |-> link_tx_valid == '0)
        else $error("byte forwarded while disabled");
    pin_bypass_a: assert property ((mode_pin_control_enable && mode_select_pin) [*8]
        |-> bypass_active) else $error("mode pin high but base mode");
    pin_base_a: assert property ((mode_pin_control_enable && !mode_select_pin
        && !bypass_enable) [*8] |-> !bypass_active) else $error("mode pin low but bypass");
endmodule : ucc_chk

bind ucc_base ucc_chk u_chk (.*);

//--- testbench/ucc_host.sv
// Host microcontroller model on the shared UART line
`timescale 1ns/1ns
module ucc_host (
    input  wire logic        clock,
    input  wire logic [15:0] bit_cycles,
    input  wire logic        rx_line,
    output logic             tx_line,
    output logic [7:0]       rx_byte,
    output logic             rx_done
);
    initial begin
        tx_line = 1'b1;
        rx_byte = 8'h00;
        rx_done = 1'b0;
    end
    // One 8N1 frame, LSB first
    task put(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            tx_line = f[i];
            repeat (bit_cycles) @(posedge clock);
            #1;
        end
    endtask : put
    // Line held high 48 bit times after the last stop bit, past any response
    task quiet();
        repeat (48 * bit_cycles) @(posedge clock);
        #1;
    endtask : quiet
    // Receiver samples mid-bit; pulse lands off the edge to avoid races
    always begin
        @(negedge rx_line);
        repeat (bit_cycles + bit_cycles / 2) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            rx_byte[i] = rx_line;
            repeat (bit_cycles) @(posedge clock);
        end
        #1 rx_done = 1'b1;
        @(posedge clock);
        #1 rx_done = 1'b0;
    end
endmodule : ucc_host

//--- verilog/README_unused.sv
// Reserved file; holds no code

//--- verilog/ucc_base.sv
// UART control channel: base and bypass modes, first byte delay, link steering
`timescale 1ns/1ns
module ucc_base
    import ucc_pkg::*;
#(
    parameter logic [ucc_pkg::TIMEOUT_WIDTH-1:0] TIMEOUT_2MS_CYCLES  =
        ucc_pkg::TIMEOUT_WIDTH'(ucc_pkg::BYPASS_IDLE_TIMEOUT_2MS_CYC),
    parameter logic [ucc_pkg::TIMEOUT_WIDTH-1:0] TIMEOUT_8MS_CYCLES  =
        ucc_pkg::TIMEOUT_WIDTH'(ucc_pkg::BYPASS_IDLE_TIMEOUT_8MS_CYC),
    parameter logic [ucc_pkg::TIMEOUT_WIDTH-1:0] TIMEOUT_32MS_CYCLES =
        ucc_pkg::TIMEOUT_WIDTH'(ucc_pkg::BYPASS_IDLE_TIMEOUT_32MS_CYC)
) (
    input  wire logic                          clock,
    input  wire logic                          reset,
    input  wire logic                          uart_rx_pin,
    output logic                               uart_tx_pin,
    input  wire logic                          mode_select_pin,
    input  wire logic [15:0]                   bit_cycles,
    input  wire logic [1:0]                    uart_first_byte_delay,
    input  wire logic                          local_channel_pin_disable,
    input  wire logic                          remote_channel_disable,
    input  wire logic                          mode_pin_control_enable,
    input  wire logic                          bypass_enable_set,
    input  wire logic [1:0]                    bypass_idle_timeout,
    input  wire logic                          link_select,
    output logic [7:0]                         link_tx_data,
    output logic [ucc_pkg::NUM_LINKS-1:0]      link_tx_valid,
    output logic [ucc_pkg::NUM_LINKS-1:0]      link_tx_bypass_level,
    input  wire logic [ucc_pkg::NUM_LINKS*8-1:0] link_rx_data,
    input  wire logic [ucc_pkg::NUM_LINKS-1:0] link_rx_valid,
    output logic [ucc_pkg::NUM_LINKS-1:0]      link_rx_ready,
    input  wire logic [ucc_pkg::NUM_LINKS-1:0] link_rx_bypass_level,
    output logic                               bypass_active,
    output logic                               bypass_enable,
    output logic                               rx_frame_error
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [NUM_SYNC-1:0] sync_pins;
    logic [NUM_SYNC-1:0] sync_levels;
    localparam logic [NUM_SYNC-1:0] SYNC_RESET = {RESET_BYPASS, LINE_IDLE};

    assign sync_pins = {mode_select_pin, uart_rx_pin};

    // One synchroniser per asynchronous pin
    generate
        for (genvar g = 0; g < NUM_SYNC; g++) begin : g_sync
            ucc_sync #(
                .RESET_LEVEL (SYNC_RESET[g])
            ) u_sync (
                .clock (clock),
                .reset (reset),
                .pin   (sync_pins[g]),
                .level (sync_levels[g])
            );
        end
    endgenerate

    logic rx_line;
    logic mode_pin_level;

    // A disabled pin looks like an idle line to the receiver
    assign rx_line        = local_channel_pin_disable ? LINE_IDLE
                                                      : sync_levels[SYNC_HOST_RX];
    assign mode_pin_level = sync_levels[SYNC_MODE_PIN];

    ////////////////////////////////////////////////////////////////////////////
    // Mode control

    logic [TIMEOUT_WIDTH-1:0] idle_cycles;
    logic [TIMEOUT_WIDTH-1:0] idle_limit;
    logic                     idle_expired;

    // Timeout selection, never expires in the last code
    always_comb begin
        case (bypass_idle_timeout)
            BYPASS_IDLE_TIMEOUT_CODE_2MS:  idle_limit = TIMEOUT_2MS_CYCLES;
            BYPASS_IDLE_TIMEOUT_CODE_8MS:  idle_limit = TIMEOUT_8MS_CYCLES;
            BYPASS_IDLE_TIMEOUT_CODE_32MS: idle_limit = TIMEOUT_32MS_CYCLES;
            default:             idle_limit = '1;
        endcase
    end

    assign idle_expired = (bypass_idle_timeout != BYPASS_IDLE_TIMEOUT_CODE_NONE)
                          && (idle_cycles >= idle_limit);

    // High-time counter; any low level is activity and restarts it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            idle_cycles <= '0;
        end else if (!bypass_enable || !rx_line) begin
            idle_cycles <= '0;
        end else if (idle_cycles != '1) begin
            idle_cycles <= idle_cycles + 1'b1;
        end
    end

    // Software bypass bit; a new set wins over a timeout clear
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bypass_enable <= RESET_BYPASS;
        end else if (bypass_enable_set) begin
            bypass_enable <= 1'b1;
        end else if (idle_expired) begin
            bypass_enable <= 1'b0;
        end
    end

    // Mode pin overrides the software bit while its control is on
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bypass_active <= RESET_BYPASS;
        end else if (mode_pin_control_enable) begin
            bypass_active <= mode_pin_level;
        end else begin
            bypass_active <= bypass_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host-side receiver, base mode only

    ucc_rx_state_e rx_state;
    logic [15:0]   rx_cnt;
    logic [2:0]    rx_idx;
    logic [7:0]    rx_shift;
    logic          rx_done;

    // Sample mid-bit; each bit lasts the configured cycle count
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_state       <= UCC_RX_IDLE;
            rx_cnt         <= '0;
            rx_idx         <= '0;
            rx_shift       <= '0;
            rx_done        <= 1'b0;
            rx_frame_error <= 1'b0;
        end else begin
            rx_done        <= 1'b0;
            rx_frame_error <= 1'b0;
            if (bypass_active) begin
                rx_state <= UCC_RX_IDLE;
            end else begin
                case (rx_state)
                    UCC_RX_IDLE: begin
                        if (!rx_line) begin
                            rx_cnt   <= {1'b0, bit_cycles[15:1]};
                            rx_state <= UCC_RX_START;
                        end
                    end
                    UCC_RX_START: begin
                        if (rx_cnt != '0) begin
                            rx_cnt <= rx_cnt - 1'b1;
                        end else if (!rx_line) begin
                            rx_cnt   <= bit_cycles - 1'b1;
                            rx_idx   <= '0;
                            rx_state <= UCC_RX_DATA;
                        end else begin
                            rx_state <= UCC_RX_IDLE; // Glitch, not a start bit
                        end
                    end
                    UCC_RX_DATA: begin
                        if (rx_cnt != '0) begin
                            rx_cnt <= rx_cnt - 1'b1;
                        end else begin
                            rx_shift <= {rx_line, rx_shift[7:1]};
                            rx_cnt   <= bit_cycles - 1'b1;
                            rx_idx   <= rx_idx + 1'b1;
                            if (rx_idx == LAST_DATA_BIT) begin
                                rx_state <= UCC_RX_STOP;
                            end
                        end
                    end
                    UCC_RX_STOP: begin
                        if (rx_cnt != '0) begin
                            rx_cnt <= rx_cnt - 1'b1;
                        end else begin
                            rx_done        <= rx_line; // Every byte with a high stop bit, single or burst
                            rx_frame_error <= !rx_line;
                            rx_state       <= UCC_RX_IDLE;
                        end
                    end
                    default: rx_state <= UCC_RX_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link-side outputs, steered to one link only

    // Frames go to the selected link as bytes, never to all of them
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            link_tx_data  <= '0;
            link_tx_valid <= '0;
        end else begin
            link_tx_valid <= '0;
            if (rx_done && !remote_channel_disable && !bypass_active) begin
                link_tx_data               <= rx_shift;
                link_tx_valid[link_select] <= 1'b1;
            end
        end
    end

    // Bypass carries the raw line level; unselected links rest idle
    generate
        for (genvar l = 0; l < NUM_LINKS; l++) begin : g_bypass
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    link_tx_bypass_level[l] <= LINE_IDLE;
                end else if (bypass_active && (link_select == l)) begin
                    link_tx_bypass_level[l] <= rx_line;
                end else begin
                    link_tx_bypass_level[l] <= LINE_IDLE;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Link-side receive holding byte

    logic       hold_full;
    logic [7:0] hold_data;
    logic       take;
    logic       load;
    logic       next_hold_full;
    logic [7:0] sel_rx_data;

    assign sel_rx_data    = link_rx_data[link_select*8 +: 8];
    assign take           = link_rx_valid[link_select] && link_rx_ready[link_select];
    assign next_hold_full = (hold_full && !load) || take;

    // One byte of storage; ready follows it so no byte is dropped
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hold_full     <= 1'b0;
            hold_data     <= '0;
            link_rx_ready <= '0;
        end else begin
            hold_full     <= next_hold_full;
            link_rx_ready <= '0;
            if (!next_hold_full && !bypass_active) begin
                link_rx_ready[link_select] <= 1'b1;
            end
            if (take) begin
                hold_data <= sel_rx_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter toward the UART pin

    ucc_tx_state_e tx_state;
    logic [15:0]   tx_cnt;
    logic [3:0]    tx_bit;
    logic [7:0]    tx_shift;
    logic [5:0]    quiet_bits;
    logic [3:0]    delay_bits;
    logic          tx_level;
    logic          first_of_transaction;
    logic [15:0]   quiet_div;
    logic          quiet_tick;

    // Delay length per field code
    always_comb begin
        case (uart_first_byte_delay)
            OUT_DELAY_CODE_0: delay_bits = OUT_DELAY_BITS_0;
            OUT_DELAY_CODE_4: delay_bits = OUT_DELAY_BITS_4;
            OUT_DELAY_CODE_8: delay_bits = OUT_DELAY_BITS_8;
            OUT_DELAY_CODE_1: delay_bits = OUT_DELAY_BITS_1;
            default:          delay_bits = OUT_DELAY_BITS_0;
        endcase
    end

    // A byte after the full turnaround gap opens a new transaction
    assign first_of_transaction = (quiet_bits >= TURNAROUND_BITS);
    assign load = hold_full && (tx_state == UCC_TX_IDLE);

    // Line level from the state; registered once more at the pin
    always_comb begin
        case (tx_state)
            UCC_TX_START: tx_level = 1'b0;
            UCC_TX_DATA:  tx_level = tx_shift[tx_bit[2:0]];
            default:      tx_level = LINE_IDLE;
        endcase
    end

    // Bit-timed sender with optional hold-off before the first byte
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tx_state <= UCC_TX_IDLE;
            tx_cnt   <= '0;
            tx_bit   <= '0;
            tx_shift <= '0;
        end else begin
            case (tx_state)
                UCC_TX_IDLE: begin
                    tx_cnt <= bit_cycles - 1'b1;
                    tx_bit <= '0;
                    if (load) begin
                        tx_shift <= hold_data;
                        if (first_of_transaction && (delay_bits != '0)) begin
                            tx_state <= UCC_TX_DELAY;
                        end else begin
                            tx_state <= UCC_TX_START;
                        end
                    end
                end
                UCC_TX_DELAY: begin
                    if (tx_cnt != '0) begin
                        tx_cnt <= tx_cnt - 1'b1;
                    end else begin
                        tx_cnt <= bit_cycles - 1'b1;
                        if (tx_bit == delay_bits - 1'b1) begin
                            tx_bit   <= '0;
                            tx_state <= UCC_TX_START;
                        end else begin
                            tx_bit <= tx_bit + 1'b1;
                        end
                    end
                end
                UCC_TX_START: begin
                    if (tx_cnt != '0) begin
                        tx_cnt <= tx_cnt - 1'b1;
                    end else begin
                        tx_cnt   <= bit_cycles - 1'b1;
                        tx_bit   <= '0;
                        tx_state <= UCC_TX_DATA;
                    end
                end
                UCC_TX_DATA: begin
                    if (tx_cnt != '0) begin
                        tx_cnt <= tx_cnt - 1'b1;
                    end else begin
                        tx_cnt <= bit_cycles - 1'b1;
                        tx_bit <= tx_bit + 1'b1;
                        if (tx_bit[2:0] == LAST_DATA_BIT) begin
                            tx_state <= UCC_TX_STOP;
                        end
                    end
                end
                UCC_TX_STOP: begin
                    if (tx_cnt != '0) begin
                        tx_cnt <= tx_cnt - 1'b1;
                    end else begin
                        tx_state <= UCC_TX_IDLE;
                    end
                end
                default: tx_state <= UCC_TX_IDLE;
            endcase
        end
    end

    // Quiet time counted in bit times from the last stop bit end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            quiet_bits <= TURNAROUND_BITS;
        end else if (tx_state != UCC_TX_IDLE || bypass_active) begin
            quiet_bits <= '0;
        end else if (quiet_tick && !first_of_transaction) begin
            quiet_bits <= quiet_bits + 1'b1;
        end
    end

    // One tick per idle bit time; restarts whenever the sender is busy
    assign quiet_tick = (quiet_div == '0);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            quiet_div <= '0;
        end else if (tx_state != UCC_TX_IDLE || quiet_tick) begin
            quiet_div <= bit_cycles - 1'b1;
        end else begin
            quiet_div <= quiet_div - 1'b1;
        end
    end

    // Pin driver: frames in base, raw link level in bypass, idle when off
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            uart_tx_pin <= LINE_IDLE;
        end else if (local_channel_pin_disable) begin
            uart_tx_pin <= LINE_IDLE;
        end else if (bypass_active) begin
            uart_tx_pin <= link_rx_bypass_level[link_select];
        end else begin
            uart_tx_pin <= tx_level;
        end
    end

endmodule : ucc_base

//--- verilog/ucc_pkg.sv
// Constants and types shared by the UART control channel design
package ucc_pkg;

    // Device clock
    localparam int CLOCK_PERIOD_NS   = 10;

    // Bypass idle timeout choices, in microseconds and in clock cycles
    localparam int BYPASS_IDLE_TIMEOUT_2MS_US  = 2000;
    localparam int BYPASS_IDLE_TIMEOUT_8MS_US  = 8000;
    localparam int BYPASS_IDLE_TIMEOUT_32MS_US = 32000;
    localparam int BYPASS_IDLE_TIMEOUT_2MS_CYC  = BYPASS_IDLE_TIMEOUT_2MS_US * 1000 / CLOCK_PERIOD_NS;
    localparam int BYPASS_IDLE_TIMEOUT_8MS_CYC  = BYPASS_IDLE_TIMEOUT_8MS_US * 1000 / CLOCK_PERIOD_NS;
    localparam int BYPASS_IDLE_TIMEOUT_32MS_CYC = BYPASS_IDLE_TIMEOUT_32MS_US * 1000 / CLOCK_PERIOD_NS;
    localparam int TIMEOUT_WIDTH     = 22;

    // Bypass idle timeout field codes
    localparam logic [1:0] BYPASS_IDLE_TIMEOUT_CODE_2MS  = 2'h0;
    localparam logic [1:0] BYPASS_IDLE_TIMEOUT_CODE_8MS  = 2'h1;
    localparam logic [1:0] BYPASS_IDLE_TIMEOUT_CODE_32MS = 2'h2;
    localparam logic [1:0] BYPASS_IDLE_TIMEOUT_CODE_NONE = 2'h3;

    // First byte delay field codes and their lengths in bit times
    localparam logic [1:0] OUT_DELAY_CODE_0 = 2'h0;
    localparam logic [1:0] OUT_DELAY_CODE_4 = 2'h1;
    localparam logic [1:0] OUT_DELAY_CODE_8 = 2'h2;
    localparam logic [1:0] OUT_DELAY_CODE_1 = 2'h3;
    localparam logic [3:0] OUT_DELAY_BITS_0 = 4'h0;
    localparam logic [3:0] OUT_DELAY_BITS_4 = 4'h4;
    localparam logic [3:0] OUT_DELAY_BITS_8 = 4'h8;
    localparam logic [3:0] OUT_DELAY_BITS_1 = 4'h1;

    // Quiet time that separates two transactions, in bit times
    localparam logic [5:0] TURNAROUND_BITS = 6'h30;

    // Frame layout, link count and synchroniser indices
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    localparam int         NUM_LINKS     = 2;
    localparam int         NUM_SYNC      = 2;
    localparam int         SYNC_HOST_RX  = 0;
    localparam int         SYNC_MODE_PIN = 1;

    // Reset values
    localparam logic       RESET_BYPASS  = 1'b0;
    localparam logic       LINE_IDLE     = 1'b1;

    typedef enum logic [1:0] {
        UCC_RX_IDLE  = 2'b00,
        UCC_RX_START = 2'b01,
        UCC_RX_DATA  = 2'b10,
        UCC_RX_STOP  = 2'b11
    } ucc_rx_state_e;

    typedef enum logic [2:0] {
        UCC_TX_IDLE  = 3'b000,
        UCC_TX_DELAY = 3'b001,
        UCC_TX_START = 3'b010,
        UCC_TX_DATA  = 3'b011,
        UCC_TX_STOP  = 3'b100
    } ucc_tx_state_e;

endpackage : ucc_pkg

//--- verilog/ucc_sync.sv
// Three-stage pin synchroniser that changes once stages two and three agree
`timescale 1ns/1ns
module ucc_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic pin,
    output logic      level
);

    logic stage1;
    logic stage2;
    logic stage3;

    // Stage one feeds only stage two to keep metastability contained
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Accept a change only when two settled stages agree
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            level <= RESET_LEVEL;
        end else if (stage2 == stage3) begin
            level <= stage3;
        end
    end

endmodule : ucc_sync
